// ===== vmc_defines.svh
/*
  Offsets, field positions, reset values and fixed codes of the
  product-data, extended-access and interrupt-message capability bank.
  Assumes the including file wants plain `define macros only.
*/
`ifndef VMC_DEFINES_SVH
`define VMC_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define VMC_OFF_PD_CAP 8'hd8
`define VMC_OFF_PD_DATA 8'hdc
`define VMC_OFF_EXT_IDX 8'he0
`define VMC_OFF_EXT_DATA 8'he4
`define VMC_OFF_MSG_CAP 8'hf0

// ----------------------------------------
// Capability headers
// ----------------------------------------
`define VMC_PD_CAP_CODE 8'h03
`define VMC_PD_NEXT_LINK 8'hf0
`define VMC_MSG_CAP_CODE 8'h05
`define VMC_MSG_NEXT_LINK 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define VMC_OP_BIT 31
`define VMC_IDX_MSB 23
`define VMC_IDX_LSB 18
`define VMC_EXT_IDX_MSB 11
`define VMC_MSI_EN_BIT 16
`define VMC_MMC_MSB 19
`define VMC_MMC_LSB 17
`define VMC_MME_MSB 22
`define VMC_MME_LSB 20
`define VMC_ADDR64_BIT 23

// ----------------------------------------
// Values and reset values
// ----------------------------------------
`define VMC_PD_BASE 8'h40
`define VMC_MMC_CODE 3'h0
`define VMC_MME_RST 3'h0
`define VMC_IDX_RST 6'h00
`define VMC_EXT_IDX_RST 12'h000
`define VMC_WORD_RST 32'h0000_0000

`endif

// ===== vmc_pkg.sv
/*
  Types shared by the capability bank: request carriers and state.
  Assumes vmc_defines.svh is on the include path.
*/
package vmc_pkg;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } vmc_cfg_req_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] addr;
    logic [31:0] wdata;
  } vmc_ee_req_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [11:0] idx;
    logic [3:0] be;
    logic [31:0] wdata;
  } vmc_ext_req_s;

  // ----------------------------------------
  // EEPROM sequencer states
  // ----------------------------------------
  typedef enum logic {VMC_EE_IDLE, VMC_EE_BUSY} vmc_ee_e;

endpackage : vmc_pkg

// ===== vmc_byte_merge.sv
/*
  Byte-lane merge: each enabled lane takes the new byte, others keep old.
  Assumes a width that is a whole number of bytes.
*/
`timescale 1ns/1ps
module vmc_byte_merge #(
  parameter int W = 32
) (
  input wire logic [W-1:0] old_in, // Current value
  input wire logic [W-1:0] new_in, // Written value
  input wire logic [W/8-1:0] be_in, // Byte enables
  output logic [W-1:0] merged_out // Merged value
);

  initial begin
    if (W % 8 != 0 || W < 8) begin
      $error("vmc_byte_merge: width must be whole bytes");
    end
  end

  // ----------------------------------------
  // Lane select
  // ----------------------------------------
  for (genvar i = 0; i < W / 8; i++) begin : g_lane
    assign merged_out[8*i +: 8] = be_in[i] ? new_in[8*i +: 8] : old_in[8*i +: 8];
  end

endmodule : vmc_byte_merge

// ===== vmc_cap_bank.sv
/*
  Capability bank: product-data EEPROM window, extended register window
  and interrupt-message header with interrupt routing.
  Assumes one-cycle config strobes, an EEPROM engine answering with a
  done pulse, and an internal register port answering with an ack pulse.
*/
`timescale 1ns/1ps
`include "vmc_defines.svh"
module vmc_cap_bank #(
  parameter int DATA_W = 32
) (
  input wire logic clk_in, // Core clock, 10 MHz
  input wire logic nrst_in, // Async reset, active low
  input wire vmc_pkg::vmc_cfg_req_s cfg_in, // Config access strobe
  output logic cfg_ack_out, // Access answered, pulse
  output logic [31:0] cfg_rdata_out, // Read data
  output vmc_pkg::vmc_ee_req_s ee_out, // EEPROM cycle start
  input wire logic ee_done_in, // EEPROM cycle done, pulse
  input wire logic [31:0] ee_rdata_in, // EEPROM read word
  output vmc_pkg::vmc_ext_req_s ext_out, // Internal register access
  input wire logic ext_ack_in, // Internal access done, pulse
  input wire logic [31:0] ext_rdata_in, // Internal read word
  input wire logic int_req_in, // Interrupt request level
  output logic intx_out, // Legacy interrupt level
  output logic msi_req_out // Message request, pulse
);
  import vmc_pkg::*;

  initial begin
    if (DATA_W != 32) begin
      $error("vmc_cap_bank: only 32-bit data is served");
    end
  end

  typedef struct packed {
    vmc_ee_e ee_st;
    logic op_flag;
    logic [5:0] pd_index;
    logic [31:0] pd_data;
    logic [11:0] ext_idx;
    logic [31:0] ext_data;
    logic ext_pend;
    logic msi_en;
    logic [2:0] mme;
    logic [31:0] rdata;
    logic ack;
    vmc_ee_req_s ee;
    vmc_ext_req_s ext;
    logic intx;
    logic msi_req;
    logic int_prev;
  } vmc_state_s;

  vmc_state_s st;
  vmc_state_s next_st;

  // ----------------------------------------
  // Register images and byte merges
  // ----------------------------------------
  logic [31:0] pd_cap_word;
  logic [31:0] msg_word;
  logic [31:0] m_pdc;
  logic [31:0] m_pdd;
  logic [31:0] m_eix;
  logic [31:0] m_edt;
  logic [31:0] m_msg;
  logic ee_idle;

  // Header word at D8h and F0h
  assign pd_cap_word = {st.op_flag, 7'h00, st.pd_index, 2'b00, `VMC_PD_NEXT_LINK, `VMC_PD_CAP_CODE};
  assign msg_word = {8'h00, 1'b1, st.mme, `VMC_MMC_CODE, st.msi_en, `VMC_MSG_NEXT_LINK, `VMC_MSG_CAP_CODE};
  assign ee_idle = (st.ee_st == VMC_EE_IDLE);

  vmc_byte_merge #(.W(32)) u_pdc (
    .old_in(pd_cap_word),
    .new_in(cfg_in.wdata),
    .be_in(cfg_in.be),
    .merged_out(m_pdc)
  );
  vmc_byte_merge #(.W(32)) u_pdd (
    .old_in(st.pd_data),
    .new_in(cfg_in.wdata),
    .be_in(cfg_in.be),
    .merged_out(m_pdd)
  );
  vmc_byte_merge #(.W(32)) u_eix (
    .old_in({20'h0_0000, st.ext_idx}),
    .new_in(cfg_in.wdata),
    .be_in(cfg_in.be),
    .merged_out(m_eix)
  );
  vmc_byte_merge #(.W(32)) u_edt (
    .old_in(st.ext_data),
    .new_in(cfg_in.wdata),
    .be_in(cfg_in.be),
    .merged_out(m_edt)
  );
  vmc_byte_merge #(.W(32)) u_msg (
    .old_in(msg_word),
    .new_in(cfg_in.wdata),
    .be_in(cfg_in.be),
    .merged_out(m_msg)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.ee.req = 1'b0;
    next_st.ext.req = 1'b0;
    next_st.msi_req = 1'b0;
    // Interrupt routing by enable bit
    next_st.int_prev = int_req_in;
    next_st.intx = int_req_in & ~st.msi_en;
    if (st.msi_en && int_req_in && !st.int_prev) begin
      next_st.msi_req = 1'b1;
    end
    // EEPROM completion turns the flag over
    case (st.ee_st)
      VMC_EE_IDLE: begin
      end
      VMC_EE_BUSY: begin
        if (ee_done_in) begin
          next_st.ee_st = VMC_EE_IDLE;
          next_st.op_flag = ~st.ee.we;
          if (!st.ee.we) begin
            next_st.pd_data = ee_rdata_in;
          end
        end
      end
      default: next_st.ee_st = VMC_EE_IDLE;
    endcase
    // Internal register access completion
    if (st.ext_pend && ext_ack_in) begin
      next_st.ext_pend = 1'b0;
      next_st.ack = 1'b1;
      next_st.rdata = st.ext.we ? 32'h0000_0000 : ext_rdata_in;
      if (!st.ext.we) begin
        next_st.ext_data = ext_rdata_in;
      end
    end
    // New config access
    if ((cfg_in.rd || cfg_in.wr) && !st.ext_pend) begin
      next_st.ack = 1'b1;
      next_st.rdata = 32'h0000_0000;
      case (cfg_in.addr)
        `VMC_OFF_PD_CAP: begin
          if (cfg_in.rd) begin
            next_st.rdata = pd_cap_word;
          end else if (ee_idle) begin
            if (cfg_in.be[2]) begin
              next_st.pd_index = m_pdc[`VMC_IDX_MSB:`VMC_IDX_LSB];
            end
            if (cfg_in.be[3]) begin
              next_st.ee_st = VMC_EE_BUSY;
              next_st.op_flag = m_pdc[`VMC_OP_BIT];
              next_st.ee.req = 1'b1;
              next_st.ee.we = m_pdc[`VMC_OP_BIT];
              next_st.ee.addr = {2'b00, next_st.pd_index} + `VMC_PD_BASE;
              next_st.ee.wdata = st.pd_data;
            end
          end
        end
        `VMC_OFF_PD_DATA: begin
          if (cfg_in.rd) begin
            next_st.rdata = st.pd_data;
          end else if (ee_idle) begin
            next_st.pd_data = m_pdd;
          end
        end
        `VMC_OFF_EXT_IDX: begin
          if (cfg_in.rd) begin
            next_st.rdata = {20'h0_0000, st.ext_idx};
          end else begin
            next_st.ext_idx = m_eix[`VMC_EXT_IDX_MSB:0];
          end
        end
        `VMC_OFF_EXT_DATA: begin
          next_st.ack = 1'b0;
          next_st.ext_pend = 1'b1;
          next_st.ext.req = 1'b1;
          next_st.ext.we = cfg_in.wr;
          next_st.ext.idx = st.ext_idx;
          next_st.ext.be = cfg_in.be;
          next_st.ext.wdata = cfg_in.wdata;
          if (cfg_in.wr) begin
            next_st.ext_data = m_edt;
          end
        end
        `VMC_OFF_MSG_CAP: begin
          if (cfg_in.rd) begin
            next_st.rdata = msg_word;
          end else if (cfg_in.be[2]) begin
            next_st.msi_en = m_msg[`VMC_MSI_EN_BIT];
            next_st.mme = m_msg[`VMC_MME_MSB:`VMC_MME_LSB];
          end
        end
        default: begin
          next_st.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= '0;
      st.ee_st <= VMC_EE_IDLE;
      st.pd_index <= `VMC_IDX_RST;
      st.pd_data <= `VMC_WORD_RST;
      st.ext_idx <= `VMC_EXT_IDX_RST;
      st.ext_data <= `VMC_WORD_RST;
      st.mme <= `VMC_MME_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign cfg_ack_out = st.ack;
  assign cfg_rdata_out = st.rdata;
  assign ee_out = st.ee;
  assign ext_out = st.ext;
  assign intx_out = st.intx;
  assign msi_req_out = st.msi_req;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  logic launch_cmd;
  assign launch_cmd = cfg_in.wr && !st.ext_pend && cfg_in.addr == `VMC_OFF_PD_CAP && cfg_in.be[3] && ee_idle;

  read_launch_a: assert property (
    launch_cmd && !cfg_in.wdata[31] |=> ee_out.req && !ee_out.we && !st.op_flag
  ) else $error("read cycle not launched with flag low");

  read_hold_a: assert property (
    st.ee_st == VMC_EE_BUSY && !st.ee.we |-> !st.op_flag
  ) else $error("read flag not held low");

  read_done_a: assert property (
    st.ee_st == VMC_EE_BUSY && !st.ee.we && ee_done_in |=> st.op_flag && ee_idle
  ) else $error("read flag not set on completion");

  // Running cycle locks flag, index and data register
  busy_hold_a: assert property (
    st.ee_st == VMC_EE_BUSY && !ee_done_in
    |=> $stable(st.op_flag) && $stable(st.pd_index) && $stable(st.pd_data)
  ) else $error("product-data state moved while busy");

  write_launch_a: assert property (
    launch_cmd && cfg_in.wdata[31] |=> ee_out.req && ee_out.we && st.op_flag ##1 st.op_flag
  ) else $error("write cycle flag not held high");

  write_done_a: assert property (
    st.ee_st == VMC_EE_BUSY && st.ee.we && ee_done_in |=> !st.op_flag
  ) else $error("write flag not cleared on completion");

  ee_addr_a: assert property (
    ee_out.req |-> ee_out.addr == {2'b00, st.pd_index} + `VMC_PD_BASE
  ) else $error("eeprom address not index plus base");

  // Written word is the data register as it stood at launch
  ee_wdata_a: assert property (
    ee_out.req && ee_out.we |-> ee_out.wdata == st.pd_data
  ) else $error("eeprom write word wrong");

  read_data_a: assert property (
    st.ee_st == VMC_EE_BUSY && !st.ee.we && ee_done_in |=> st.pd_data == $past(ee_rdata_in)
  ) else $error("fetched word not presented");

  byte_lane_a: assert property (
    cfg_in.wr && !st.ext_pend && ee_idle && cfg_in.addr == `VMC_OFF_PD_DATA && cfg_in.be == 4'h1
    |=> st.pd_data[31:8] == $past(st.pd_data[31:8]) && st.pd_data[7:0] == $past(cfg_in.wdata[7:0])
  ) else $error("byte lane write wrong");

  ext_index_a: assert property (
    ext_out.req |-> ext_out.idx == st.ext_idx && st.ext_pend
  ) else $error("extended access index wrong");

  // Internal answer closes the pending access with an acknowledge
  ext_done_a: assert property (
    st.ext_pend && ext_ack_in |=> cfg_ack_out && !st.ext_pend
  ) else $error("extended access not answered");

  // Internal read word is handed back unchanged
  ext_read_a: assert property (
    st.ext_pend && ext_ack_in && !st.ext.we |=> cfg_rdata_out == $past(ext_rdata_in)
  ) else $error("extended read data wrong");

  pd_header_a: assert property (
    cfg_in.rd && !st.ext_pend && cfg_in.addr == `VMC_OFF_PD_CAP |=> cfg_ack_out && cfg_rdata_out[15:0] == 16'hf003
  ) else $error("product-data header wrong");

  msg_header_a: assert property (
    cfg_in.rd && !st.ext_pend && cfg_in.addr == `VMC_OFF_MSG_CAP |=> cfg_rdata_out[15:0] == 16'h0005
  ) else $error("message header wrong");

  intx_route_a: assert property (
    $past(st.msi_en) |-> !intx_out && (!msi_req_out || ($past(int_req_in) && !$past(st.int_prev)))
  ) else $error("interrupt routing wrong");

  // Legacy level follows the request while messages are off
  intx_level_a: assert property (
    !st.msi_en && int_req_in |=> intx_out && !msi_req_out
  ) else $error("legacy interrupt not raised");

  // Enable bit and message-enable field take the written value
  mme_write_a: assert property (
    cfg_in.wr && !st.ext_pend && cfg_in.addr == `VMC_OFF_MSG_CAP && cfg_in.be[2]
    |=> st.mme == $past(cfg_in.wdata[22:20]) && st.msi_en == $past(cfg_in.wdata[16])
  ) else $error("message control write wrong");

  msg_cap_a: assert property (
    cfg_ack_out && $past(cfg_in.rd && cfg_in.addr == `VMC_OFF_MSG_CAP && !st.ext_pend)
    |-> cfg_rdata_out[19:17] == `VMC_MMC_CODE && cfg_rdata_out[22:20] == st.mme
  ) else $error("message control fields wrong");

  read_cycle_c: cover property (launch_cmd && !cfg_in.wdata[31] ##[1:50] ee_done_in);
  write_cycle_c: cover property (launch_cmd && cfg_in.wdata[31] ##[1:50] ee_done_in);
  ext_access_c: cover property (ext_out.req ##[1:20] ext_ack_in);
  ext_read_c: cover property (ext_out.req && !ext_out.we ##[1:20] ext_ack_in);
  msi_send_c: cover property (msi_req_out);

endmodule : vmc_cap_bank

// ===== vmc_ee_model.sv
/*
  Behavioural serial EEPROM standing behind the product-data path.
  Assumes one-cycle start pulses from vmc_cap_bank on rising clk_in.
*/
`timescale 1ns/1ps
module vmc_ee_model (
  input wire logic clk_in, // Core clock
  input wire logic nrst_in, // Async reset, active low
  input wire logic slow_in, // Long cycles when high
  input wire vmc_pkg::vmc_ee_req_s ee_in, // Cycle start
  output logic done_out, // Cycle done, pulse
  output logic [31:0] rdata_out // Read word
);
  import vmc_pkg::*;
  logic [7:0] mem [0:255];
  vmc_ee_req_s cur;
  logic busy;
  int cnt;
  // ----------------------------------------
  // Contents and cycle engine
  // ----------------------------------------
  // Location x holds x xor A5h
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
  end
  // Data line toggles except when a read completes, so stale data never matches
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy <= 1'b0;
      done_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
      cnt <= 0;
    end else begin
      done_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if (!busy && ee_in.req === 1'b1) begin
        cur <= ee_in;
        busy <= 1'b1;
        cnt <= slow_in ? 6 : 0;
      end else if (busy && cnt > 0) begin
        cnt <= cnt - 1;
      end else if (busy) begin
        busy <= 1'b0;
        done_out <= 1'b1;
        for (int b = 0; b < 4; b++) begin // Byte 0 at start location
          if (cur.we) mem[8'(cur.addr + b)] <= cur.wdata[8*b +: 8];
          else rdata_out[8*b +: 8] <= mem[8'(cur.addr + b)];
        end
      end
    end
  end
endmodule : vmc_ee_model

// ===== tb.sv
/*
  Self-checking bench for vmc_cap_bank through its config strobes.
  Assumes vmc_ee_model and the design files are compiled first.
*/
`timescale 1ns/1ps
module tb;
  import vmc_pkg::*;
  logic clk_in = 1'b0, nrst_in = 1'b0, slow = 1'b0, int_req_in = 1'b0, ext_ack_in = 1'b0;
  logic cfg_ack_out, intx_out, msi_req_out, ee_done_in;
  logic [31:0] ee_rdata_in, cfg_rdata_out, rd, dc;
  logic [31:0] ext_rdata_in = 32'h0000_0000;
  vmc_cfg_req_s cfg_in = '0;
  vmc_ee_req_s ee_out;
  vmc_ext_req_s ext_out, ext_seen;
  logic [7:0] em [0:255];
  int fail_count = 0, check_count = 0, cyc = 0, ext_cnt = 0;

  always #50 clk_in = ~clk_in;

  vmc_cap_bank u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .cfg_in(cfg_in), .cfg_ack_out(cfg_ack_out),
    .cfg_rdata_out(cfg_rdata_out), .ee_out(ee_out), .ee_done_in(ee_done_in), .ee_rdata_in(ee_rdata_in),
    .ext_out(ext_out), .ext_ack_in(ext_ack_in), .ext_rdata_in(ext_rdata_in), .int_req_in(int_req_in),
    .intx_out(intx_out), .msi_req_out(msi_req_out));
  vmc_ee_model u_ee (.clk_in(clk_in), .nrst_in(nrst_in), .slow_in(slow), .ee_in(ee_out),
    .done_out(ee_done_in), .rdata_out(ee_rdata_in));

  // ----------------------------------------
  // Internal register responder and timeout
  // ----------------------------------------
  // Answers three cycles after a request; data toggles otherwise
  always @(posedge clk_in) begin
    ext_ack_in <= 1'b0;
    ext_rdata_in <= ~ext_rdata_in;
    if (ext_out.req === 1'b1) begin
      ext_seen <= ext_out;
      ext_cnt <= 3;
    end else if (ext_cnt == 1) begin
      ext_ack_in <= 1'b1;
      ext_rdata_in <= 32'h1234_5678;
      ext_cnt <= 0;
    end else if (ext_cnt > 1) ext_cnt <= ext_cnt - 1;
  end
  // Hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("unexpected %0t timeout", $time);
      end_sim;
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One strobe, then wait for the acknowledge
  task automatic acc(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
    int n;
    n = 0;
    @(negedge clk_in);
    cfg_in = '{rd: !wr, wr: wr, addr: a, be: be, wdata: wd};
    @(negedge clk_in);
    cfg_in.rd = 1'b0;
    cfg_in.wr = 1'b0;
    while (cfg_ack_out !== 1'b1 && n < 50) begin
      @(negedge clk_in);
      n++;
    end
    chk(n < 50, 1'b1);
    rd = cfg_rdata_out;
  endtask : acc
  function automatic logic [31:0] word(input logic [7:0] a);
    word = {em[a + 8'd3], em[a + 8'd2], em[a + 8'd1], em[a]};
  endfunction : word
  // Launch a cycle, check it, poll to completion
  task automatic ee_cycle(input logic we, input logic [5:0] idx);
    int n;
    acc(1'b1, 8'hd8, 4'b1100, {we, 7'h00, idx, 18'h0_0000});
    acc(1'b0, 8'hd8, 4'hf, 32'h0000_0000);
    chk(rd[31], we);
    chk({ee_out.we, ee_out.addr}, {we, 2'b01, idx});
    if (we) begin
      chk(ee_out.wdata, dc);
      acc(1'b1, 8'hdc, 4'hf, 32'hffff_ffff);
      for (int b = 0; b < 4; b++) em[8'({2'b01, idx} + b)] = dc[8*b +: 8];
    end
    n = 0;
    do begin
      acc(1'b0, 8'hd8, 4'hf, 32'h0000_0000);
      n++;
    end while (rd[31] === we && n < 40);
    chk(rd, {!we, 7'h00, idx, 18'h0_f003});
    if (!we) dc = word({2'b01, idx});
    acc(1'b0, 8'hdc, 4'hf, 32'h0000_0000);
    chk(rd, dc);
  endtask : ee_cycle
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) em[i] = 8'(i) ^ 8'ha5;
    repeat (16) @(negedge clk_in);
    nrst_in = 1'b1;
    acc(1'b0, 8'hd8, 4'hf, 32'h0000_0000);
    chk(rd, 32'h0000_f003);
    acc(1'b0, 8'hdc, 4'hf, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    acc(1'b0, 8'hf0, 4'hf, 32'h0000_0000);
    chk(rd, 32'h0080_0005);
    acc(1'b0, 8'hc4, 4'hf, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    ee_cycle(1'b0, 6'd0);
    slow = 1'b1;
    ee_cycle(1'b0, 6'd63);
    acc(1'b1, 8'hdc, 4'b0101, 32'h1122_3344);
    dc = {dc[31:24], 8'h22, dc[15:8], 8'h44};
    acc(1'b0, 8'hdc, 4'hf, 32'h0000_0000);
    chk(rd, dc);
    ee_cycle(1'b1, 6'd63);
    slow = 1'b0;
    ee_cycle(1'b0, 6'd63);
    acc(1'b1, 8'he0, 4'hf, 32'h0000_fabc);
    acc(1'b0, 8'he0, 4'hf, 32'h0000_0000);
    chk(rd, 32'h0000_0abc);
    acc(1'b1, 8'he4, 4'hf, 32'hdead_beef);
    chk({ext_seen.we, ext_seen.idx}, {1'b1, 12'habc});
    chk(ext_seen.wdata, 32'hdead_beef);
    chk(ext_seen.be, 4'hf);
    acc(1'b0, 8'he4, 4'hf, 32'h0000_0000);
    chk(rd, 32'h1234_5678);
    chk(ext_seen.we, 1'b0);
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, 8'hf0, 4'b0100, {9'h000, 3'(c), 3'b111, c[0], 16'hffff});
      acc(1'b0, 8'hf0, 4'hf, 32'h0000_0000);
      chk(rd, {9'h001, 3'(c), 3'b000, c[0], 16'h0005});
    end
    for (int m = 1; m >= 0; m--) begin
      if (m == 0) acc(1'b1, 8'hf0, 4'b0100, 32'h0000_0000);
      @(negedge clk_in);
      int_req_in = 1'b1;
      @(negedge clk_in);
      chk({intx_out, msi_req_out}, {!m[0], m[0]});
      @(negedge clk_in);
      int_req_in = 1'b0;
      chk({intx_out, msi_req_out}, {!m[0], 1'b0});
      @(negedge clk_in);
      chk({intx_out, msi_req_out}, 2'b00);
    end
    end_sim;
  end
endmodule : tb
